// *** logic/dgcs_defs.vh ***
`ifndef DGCS_DEFS_VH
`define DGCS_DEFS_VH

// register byte offsets inside the block's window
`define DGCS_OFF_CTRL 8'h00
`define DGCS_OFF_STAT 8'h04
`define DGCS_OFF_ADDR 8'h08
`define DGCS_OFF_CRC 8'h0c

// global control fields
`define DGCS_CTRL_ON 15
`define DGCS_CTRL_SUSPEND 12
`define DGCS_CTRL_BUSY 11
`define DGCS_CTRL_RESET 32'h00000000

// last access status fields
`define DGCS_STAT_DIR 3
`define DGCS_STAT_CH_HI 2
`define DGCS_STAT_CH_LO 0
`define DGCS_STAT_RESET 32'h00000000
`define DGCS_ADDR_RESET 32'h00000000

// crc control fields
`define DGCS_CRC_CRC_BYTE_ORDER_HI 29
`define DGCS_CRC_CRC_BYTE_ORDER_LO 28
`define DGCS_CRC_WBO 27
`define DGCS_CRC_CRC_BIT_REFLECT 24
`define DGCS_CRC_POLYNOMIAL_LENGTH_HI 12
`define DGCS_CRC_POLYNOMIAL_LENGTH_LO 8
`define DGCS_CRC_EN 7
`define DGCS_CRC_APP 6
`define DGCS_CRC_TYP 5
`define DGCS_CRC_CH_HI 2
`define DGCS_CRC_CH_LO 0
`define DGCS_CRC_WMASK 32'h39001fe7
`define DGCS_CRC_RESET 32'h00000000

// axi responses
`define DGCS_RESP_OKAY 2'h0
`define DGCS_RESP_SLVERR 2'h2

// data path
`define DGCS_FIFO_DEPTH 8
`define DGCS_FIFO_AW 3
`define DGCS_WORD_W 69

`endif

// *** logic/dgcs_fifo.v ***
module dgcs_fifo #(
	parameter W = 69,
	parameter D = 8,
	parameter AW = 3
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// fill side
	input wire inEnNxt,
	input wire inValid,
	input wire [W-1:0] inData,
	output reg inReady_r,
	// drain side
	input wire outReady,
	output reg outValid_r,
	output reg [W-1:0] outData_r,
	output wire idle
);

	localparam [AW:0] FULL = D[AW:0];

	reg [W-1:0] mem [0:D-1];
	reg [AW-1:0] wrPtr_r;
	reg [AW-1:0] rdPtr_r;
	reg [AW:0] fill_r;
	reg [AW:0] fill_nxt;
	wire push;
	wire pop;

	assign push = inValid && inReady_r;
	// read data always come out of the output register
	assign pop = (fill_r != {(AW+1){1'b0}}) && (!outValid_r || outReady);
	assign idle = (fill_r == {(AW+1){1'b0}}) && !outValid_r;

	always @*
	begin
		fill_nxt = fill_r;
		if (push && !pop)
			fill_nxt = fill_r + {{AW{1'b0}}, 1'b1};
		else if (pop && !push)
			fill_nxt = fill_r - {{AW{1'b0}}, 1'b1};
	end

	always @(posedge clk)
	begin
		if (push)
			mem[wrPtr_r] <= inData;
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wrPtr_r <= {AW{1'b0}};
			rdPtr_r <= {AW{1'b0}};
			fill_r <= {(AW+1){1'b0}};
			inReady_r <= 1'b0;
			outValid_r <= 1'b0;
			outData_r <= {W{1'b0}};
		end
		else
		begin
			fill_r <= fill_nxt;
			// ready is registered, so it promises room for one more push
			inReady_r <= inEnNxt && (fill_nxt < FULL);
			if (push)
				wrPtr_r <= wrPtr_r + {{(AW-1){1'b0}}, 1'b1};
			if (pop)
			begin
				rdPtr_r <= rdPtr_r + {{(AW-1){1'b0}}, 1'b1};
				outData_r <= mem[rdPtr_r];
				outValid_r <= 1'b1;
			end
			else if (outReady)
				outValid_r <= 1'b0;
		end
	end

endmodule

// *** logic/dgcs_axil_slave.v ***
`include "dgcs_defs.vh"

module dgcs_axil_slave (
	// clock and reset
	input wire clk,
	input wire rst,
	// write address and data
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// read address
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// register file side
	output wire wrEn,
	output wire [7:0] wrAddr,
	output wire [31:0] wrData,
	output wire [3:0] wrStrb,
	input wire wrErr,
	output wire [7:0] rdAddr,
	input wire [31:0] rdData,
	input wire rdErr
);

	reg awHeld_r;
	reg wHeld_r;
	reg arHeld_r;
	reg [7:0] awAddr_r;
	reg [31:0] wData_r;
	reg [3:0] wStrb_r;
	reg [7:0] arAddr_r;

	// address and data may arrive in either order; the write waits for both
	assign wrEn = awHeld_r && wHeld_r && !s_axi_bvalid;
	assign wrAddr = awAddr_r;
	assign wrData = wData_r;
	assign wrStrb = wStrb_r;
	assign rdAddr = arAddr_r;

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_arready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `DGCS_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `DGCS_RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			arHeld_r <= 1'b0;
			awAddr_r <= 8'h00;
			wData_r <= 32'h00000000;
			wStrb_r <= 4'h0;
			arAddr_r <= 8'h00;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr[7:0];
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wrEn)
			begin
				awHeld_r <= 1'b0;
				wHeld_r <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrErr ? `DGCS_RESP_SLVERR : `DGCS_RESP_OKAY;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready)
			begin
				arHeld_r <= 1'b1;
				arAddr_r <= s_axi_araddr[7:0];
				s_axi_arready <= 1'b0;
			end
			if (arHeld_r && !s_axi_rvalid)
			begin
				arHeld_r <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdData;
				s_axi_rresp <= rdErr ? `DGCS_RESP_SLVERR : `DGCS_RESP_OKAY;
			end
			else if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule

// *** logic/dgcs_top.v ***
// Behaviour
// - enable bit 15 turns the whole engine on
// - suspend bit 12 stops new bus accesses
// - activity bit 11 reads engine busy state
// - unimplemented bits ignore writes, read zero
// - status bit 3 shows last direction, read=1
// - status bits 2-0 hold last channel
// - address register holds last access, resets zero
// - crc enable routes selected channel through crc
// - crc channel field picks channel 0 to 7
// - crc type selects checksum or polynomial crc
// - append mode feeds crc only, writes result
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`include "dgcs_defs.vh"

module dgcs_top (
	// clock and reset
	input wire clk,
	input wire rst,
	// axi4-lite register port
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	// access requests from the channel engines
	input wire accValid,
	input wire [31:0] accAddr,
	input wire [31:0] accData,
	input wire [2:0] accChannel,
	input wire accRead,
	input wire accLast,
	output wire accReady,
	// accesses toward the system data bus
	output reg busValid_r,
	input wire busReady,
	output reg [31:0] busAddr_r,
	output reg [31:0] busData_r,
	output reg [2:0] busChannel_r,
	output reg busRead_r,
	output reg busLast_r,
	// crc routing of the offered access
	output reg busCrcRoute_r,
	output reg busToDest_r,
	output reg busCrcType_r,
	output reg crcAppendWrite_r,
	// crc settings for the crc unit
	output reg [31:0] crcControl_r,
	// global state
	output reg engineActiveFlag_r
);

	localparam W = `DGCS_WORD_W;

	reg on_r;
	reg on_nxt;
	reg suspend_r;
	reg suspend_nxt;
	reg [31:0] crc_nxt;
	reg lastAccessDirection_r;
	reg [2:0] lastChannelNumber_r;
	reg [31:0] lastAccessAddress_r;
	reg [31:0] rdMux;
	reg rdErr;
	reg wrErr;
	reg [31:0] merged;

	wire wrEn;
	wire [7:0] wrAddr;
	wire [31:0] wrData;
	wire [3:0] wrStrb;
	wire [7:0] rdAddr;
	wire [31:0] byteMask;
	wire fifoOutValid;
	wire [W-1:0] fifoOutData;
	wire fifoIdle;
	wire stageLoad;
	wire busTaken;
	wire [W-1:0] accWord;
	wire routeHit;

	dgcs_axil_slave bus (
		.clk(clk),
		.rst(rst),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wrEn(wrEn),
		.wrAddr(wrAddr),
		.wrData(wrData),
		.wrStrb(wrStrb),
		.wrErr(wrErr),
		.rdAddr(rdAddr),
		.rdData(rdMux),
		.rdErr(rdErr)
	);

	assign byteMask = {{8{wrStrb[3]}}, {8{wrStrb[2]}}, {8{wrStrb[1]}}, {8{wrStrb[0]}}};

	// address decode for the write direction
	always @*
	begin
		wrErr = 1'b1;
		if (wrAddr == `DGCS_OFF_CTRL || wrAddr == `DGCS_OFF_CRC)
			wrErr = 1'b0;
		// read-only registers accept the write and drop it
		if (wrAddr == `DGCS_OFF_STAT || wrAddr == `DGCS_OFF_ADDR)
			wrErr = 1'b0;
	end

	// global control write, honouring byte strobes
	always @*
	begin
		on_nxt = on_r;
		suspend_nxt = suspend_r;
		if (wrEn && wrAddr == `DGCS_OFF_CTRL)
		begin
			if (wrStrb[1])
			begin
				on_nxt = wrData[`DGCS_CTRL_ON];
				suspend_nxt = wrData[`DGCS_CTRL_SUSPEND];
			end
		end
	end

	// crc control write; only implemented bits survive
	always @*
	begin
		merged = (crcControl_r & ~byteMask) | (wrData & byteMask);
		crc_nxt = crcControl_r;
		if (wrEn && wrAddr == `DGCS_OFF_CRC)
		begin
			crc_nxt = merged & `DGCS_CRC_WMASK;
			// reordered writes rule out append mode
			if (crc_nxt[`DGCS_CRC_WBO])
				crc_nxt[`DGCS_CRC_APP] = 1'b0;
		end
	end

	// read data; every unimplemented position reads zero
	always @*
	begin
		rdMux = 32'h00000000;
		rdErr = 1'b0;
		case (rdAddr)
			`DGCS_OFF_CTRL:
			begin
				rdMux[`DGCS_CTRL_ON] = on_r;
				rdMux[`DGCS_CTRL_SUSPEND] = suspend_r;
				rdMux[`DGCS_CTRL_BUSY] = engineActiveFlag_r;
			end
			`DGCS_OFF_STAT:
			begin
				rdMux[`DGCS_STAT_DIR] = lastAccessDirection_r;
				rdMux[`DGCS_STAT_CH_HI:`DGCS_STAT_CH_LO] = lastChannelNumber_r;
			end
			`DGCS_OFF_ADDR:
				rdMux = lastAccessAddress_r;
			`DGCS_OFF_CRC:
				rdMux = crcControl_r;
			default:
				rdErr = 1'b1;
		endcase
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			on_r <= 1'b0;
			suspend_r <= 1'b0;
			crcControl_r <= `DGCS_CRC_RESET;
		end
		else
		begin
			on_r <= on_nxt;
			suspend_r <= suspend_nxt;
			crcControl_r <= crc_nxt;
		end
	end

	// the fifo only takes requests while the engine is on
	assign accWord = {accLast, accRead, accChannel, accData, accAddr};

	dgcs_fifo #(
		.W(W),
		.D(`DGCS_FIFO_DEPTH),
		.AW(`DGCS_FIFO_AW)
	) queue (
		.clk(clk),
		.rst(rst),
		.inEnNxt(on_nxt),
		.inValid(accValid),
		.inData(accWord),
		.inReady_r(accReady),
		.outReady(stageLoad),
		.outValid_r(fifoOutValid),
		.outData_r(fifoOutData),
		.idle(fifoIdle)
	);

	// a suspended or disabled engine starts no new access, but an access
	// already offered on the bus is held until taken so the bus never sees
	// a withdrawn request
	assign stageLoad = on_r && !suspend_r && (!busValid_r || busReady);
	assign busTaken = busValid_r && busReady;
	assign routeHit = crcControl_r[`DGCS_CRC_EN] &&
		(fifoOutData[66:64] == crcControl_r[`DGCS_CRC_CH_HI:`DGCS_CRC_CH_LO]);

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			busValid_r <= 1'b0;
			busAddr_r <= 32'h00000000;
			busData_r <= 32'h00000000;
			busChannel_r <= 3'h0;
			busRead_r <= 1'b0;
			busLast_r <= 1'b0;
			busCrcRoute_r <= 1'b0;
			busToDest_r <= 1'b0;
			busCrcType_r <= 1'b0;
		end
		else if (fifoOutValid && stageLoad)
		begin
			busValid_r <= 1'b1;
			busAddr_r <= fifoOutData[31:0];
			busData_r <= fifoOutData[63:32];
			busChannel_r <= fifoOutData[66:64];
			busRead_r <= fifoOutData[67];
			busLast_r <= fifoOutData[68];
			busCrcRoute_r <= routeHit;
			// append mode keeps routed writes away from the destination
			busToDest_r <= !(routeHit && crcControl_r[`DGCS_CRC_APP]);
			busCrcType_r <= crcControl_r[`DGCS_CRC_TYP];
		end
		else if (busReady)
			busValid_r <= 1'b0;
	end

	// last-access records and end-of-block crc write request
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			lastAccessDirection_r <= 1'b0;
			lastChannelNumber_r <= 3'h0;
			lastAccessAddress_r <= `DGCS_ADDR_RESET;
			crcAppendWrite_r <= 1'b0;
			engineActiveFlag_r <= 1'b0;
		end
		else
		begin
			crcAppendWrite_r <= busTaken && busLast_r && busCrcRoute_r && !busToDest_r;
			if (busTaken)
			begin
				lastAccessDirection_r <= busRead_r;
				lastChannelNumber_r <= busChannel_r;
				lastAccessAddress_r <= busAddr_r;
			end
			// busy while on or while queued or offered data remain
			engineActiveFlag_r <= on_nxt || busValid_r || !fifoIdle;
		end
	end

endmodule

// *** verif/dgcs_monitor.sv ***
module dgcs_monitor (
	// clock and reset
	input wire clk,
	input wire rst,
	// register port
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [1:0] s_axi_bresp,
	// data bus side
	input wire busValid_r,
	input wire busReady,
	input wire [31:0] busAddr_r,
	input wire [2:0] busChannel_r,
	input wire busRead_r,
	input wire busLast_r,
	input wire busCrcRoute_r,
	input wire busToDest_r,
	input wire busCrcType_r,
	input wire crcAppendWrite_r,
	input wire [31:0] crcControl_r,
	input wire engineActiveFlag_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	read_latency_a: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
		else $error("read answer late");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data moved");
	busy_seen_a: assert property (busValid_r |=> engineActiveFlag_r)
		else $error("busy low during transfer");
	offer_hold_a: assert property (busValid_r && !busReady |=> busValid_r && $stable({busAddr_r, busChannel_r, busRead_r}))
		else $error("offered access changed");
	crc_route_a: assert property (busValid_r |-> busCrcRoute_r == (crcControl_r[7] && busChannel_r == crcControl_r[2:0]))
		else $error("crc routing wrong");
	crc_dest_a: assert property (busValid_r |-> busToDest_r == !(busCrcRoute_r && crcControl_r[6]))
		else $error("destination routing wrong");
	crc_type_a: assert property (busValid_r |-> busCrcType_r == crcControl_r[5])
		else $error("crc type wrong");
	crc_unused_a: assert property ((crcControl_r & ~32'h39001fe7) == 32'h00000000)
		else $error("unused crc bits set");
	append_pulse_a: assert property (crcAppendWrite_r |-> $past(busValid_r && busReady && busLast_r && busCrcRoute_r && !busToDest_r) ##1 !crcAppendWrite_r)
		else $error("append write pulse wrong");
	cover property (crcAppendWrite_r);
	cover property (busValid_r && !busReady);
	cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

bind dgcs_top dgcs_monitor mon (.clk, .rst, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .busValid_r, .busReady,
	.busAddr_r, .busChannel_r, .busRead_r, .busLast_r, .busCrcRoute_r, .busToDest_r, .busCrcType_r,
	.crcAppendWrite_r, .crcControl_r, .engineActiveFlag_r);

// *** verif/dgcs_bus_model.sv ***
module dgcs_bus_model (
	// clock and reset
	input wire clk,
	input wire rst,
	// behaviour set by the bench
	input wire stall,
	input wire slow,
	// data bus handshake
	output reg busReady_r
);
	timeunit 1ns;
	timeprecision 1ns;
	// slow mode takes every other cycle, as when the cpu shares the bus
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			busReady_r <= 1'b0;
		else
			busReady_r <= !stall && (!slow || !busReady_r);
	end
endmodule

// *** verif/dma_global_control_status_tb.sv ***
`define CHK(a, b) begin checkCount++; if ((a) !== (b)) begin numErrors++; $display("[ERR] %0t got %0h want %0h", $time, a, b); end end
module dma_global_control_status_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, accValid, accRead, accLast;
	logic stall, slow, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, accReady, busValid_r;
	logic busReady, busRead_r, busLast_r, busCrcRoute_r, busToDest_r, busCrcType_r, crcAppendWrite_r, engineActiveFlag_r;
	logic rte, dst, typ;
	logic [31:0] dat;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, accAddr, accData, s_axi_rdata, busAddr_r, busData_r, crcControl_r;
	logic [3:0] s_axi_wstrb, c;
	logic [2:0] accChannel, busChannel_r;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int numErrors = 0, checkCount = 0, hs = 0, apw = 0, n, base;

	dgcs_top uut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .accValid, .accAddr, .accData, .accChannel, .accRead,
		.accLast, .accReady, .busValid_r, .busReady, .busAddr_r, .busData_r, .busChannel_r, .busRead_r, .busLast_r,
		.busCrcRoute_r, .busToDest_r, .busCrcType_r, .crcAppendWrite_r, .crcControl_r, .engineActiveFlag_r);
	dgcs_bus_model bm (.clk, .rst, .stall, .slow, .busReady_r(busReady));

	initial
	begin
		clk = 0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk)
	begin
		if (busValid_r && busReady)
		begin
			hs <= hs + 1;
			rte <= busCrcRoute_r;
			dst <= busToDest_r;
			typ <= busCrcType_r;
			dat <= busData_r;
		end
		if (crcAppendWrite_r)
			apw <= apw + 1;
	end

	task wr(input [7:0] a, input [31:0] d, input [1:0] e);
		logic aw, w;
		@(posedge clk);
		aw = 0;
		w = 0;
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!(aw && w))
		begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw = 1;
				s_axi_awvalid <= 0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w = 1;
				s_axi_wvalid <= 0;
			end
		end
		do @(posedge clk); while (!s_axi_bvalid);
		s_axi_bready <= 0;
		`CHK(s_axi_bresp, e)
	endtask

	task rc(input [7:0] a, input [31:0] x, input [1:0] e);
		@(posedge clk);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge clk); while (!s_axi_rvalid);
		s_axi_rready <= 0;
		`CHK(s_axi_rdata, x)
		`CHK(s_axi_rresp, e)
	endtask

	task acc(input [31:0] a, input [2:0] ch, input r, input l);
		@(posedge clk);
		accAddr <= a;
		accData <= ~a;
		accChannel <= ch;
		accRead <= r;
		accLast <= l;
		accValid <= 1;
		do @(posedge clk); while (!accReady);
		accValid <= 0;
	endtask

	task waitHs(input int m);
		for (int i = 0; i < 300 && hs < m; i++)
			@(posedge clk);
		`CHK(hs, m)
	endtask

	task t_reset;
		rc(8'h00, 32'h0, 2'h0);
		rc(8'h04, 32'h0, 2'h0);
		rc(8'h08, 32'h0, 2'h0);
		rc(8'h0c, 32'h0, 2'h0);
		rc(8'h10, 32'h0, 2'h2);
		wr(8'h10, 32'h1, 2'h2);
	endtask

	task t_suspend;
		wr(8'h00, 32'hffffffff, 2'h0);
		rc(8'h00, 32'h00009800, 2'h0);
		acc(32'h10000010, 3'h5, 0, 0);
		repeat (20) @(posedge clk);
		`CHK(hs, 0)
		wr(8'h00, 32'h00008000, 2'h0);
		waitHs(1);
		`CHK(dat, ~32'h10000010)
		rc(8'h04, 32'h00000005, 2'h0);
		rc(8'h08, 32'h10000010, 2'h0);
	endtask

	task t_records;
		slow <= 1;
		acc(32'h20000004, 3'h2, 1, 0);
		waitHs(2);
		wr(8'h04, 32'hffffffff, 2'h0);
		rc(8'h04, 32'h0000000a, 2'h0);
		rc(8'h08, 32'h20000004, 2'h0);
		wr(8'h0c, 32'hffffffff, 2'h0);
		rc(8'h0c, 32'h39001fa7, 2'h0);
	endtask

	task t_crc;
		for (c = 0; c < 8; c++)
		begin
			wr(8'h0c, {24'h0, 2'b11, ~c[0], 2'b00, c[2:0]}, 2'h0);
			acc(32'h40000000, c[2:0], 0, 1);
			waitHs(hs + 1);
			`CHK(rte, 1'b1)
			`CHK(dst, 1'b0)
			`CHK(typ, ~c[0])
			acc(32'h40000008, c[2:0] ^ 3'h1, 0, 0);
			waitHs(hs + 1);
			`CHK({rte, dst}, 2'b01)
		end
		`CHK(apw, 8)
	endtask

	task t_fifo;
		slow <= 0;
		stall <= 1;
		base = hs;
		n = 0;
		@(posedge clk);
		accValid <= 1;
		repeat (20)
		begin
			@(posedge clk);
			if (accReady)
				n++;
		end
		accValid <= 0;
		`CHK(accReady, 1'b0)
		`CHK(n > 7, 1'b1)
		stall <= 0;
		waitHs(base + n);
		// software stays off the registers right after clearing the enable
		wr(8'h00, 32'h0, 2'h0);
		repeat (4) @(posedge clk);
		rc(8'h00, 32'h0, 2'h0);
		`CHK(accReady, 1'b0)
	endtask

	task reportAndStop;
		$display("checks %0d errors %0d", checkCount, numErrors);
		if (numErrors == 0 && checkCount > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk);
		numErrors++;
		reportAndStop;
	end

	initial
	begin
		{rst, stall, slow} = 3'b100;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, accValid, accRead, accLast} = 0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr, accAddr, accData} = 0;
		s_axi_wstrb = 4'hf;
		accChannel = 0;
		repeat (12) @(posedge clk);
		rst <= 0;
		t_reset;
		t_suspend;
		t_records;
		t_crc;
		t_fifo;
		reportAndStop;
	end
endmodule
